// ===== core/ccp_edge.sv
// pin edge detector with capture prescaler
`timescale 1ns/1ps
module ccp_edge
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // pin and mode
  input  wire logic       pin_in,
  input  wire logic [3:0] mode,
  // capture strobe
  output logic            cap
);
  ccp_edge_type s_reg, s_next;
  logic         rise;
  logic         fall;
  logic         last;

  assign rise = pin_in & ~s_reg.prev;
  assign fall = ~pin_in & s_reg.prev;

  always_comb begin
    s_next      = s_reg;
    s_next.prev = pin_in;
    last        = 1'b0;
    cap         = 1'b0;
    case (mode)
      MODE_CAP_FALL: cap = fall;
      MODE_CAP_RISE: cap = rise;
      MODE_CAP_4, MODE_CAP_16: begin
        last = (mode == MODE_CAP_4) ? (s_reg.cnt == PRESC_4) : (s_reg.cnt == PRESC_16);
        if (rise) begin
          cap        = last;
          s_next.cnt = last ? 4'h0 : s_reg.cnt + 4'h1;
        end
      end
      // leaving capture restarts the prescaler
      default: s_next.cnt = 4'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : ccp_edge

// ===== core/ccp_timebase.sv
// PWM period timer: divide by four, then count up to the period limit
`timescale 1ns/1ps
module ccp_timebase
  import ccp_pkg::*;
#(
  parameter int DIV_W = DC_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // control
  input  wire logic             run,
  input  wire logic [7:0]       period,
  // timebase
  output logic                  reload,
  output logic [DIV_W+7:0]      pos
);
  typedef struct packed {
    logic [DIV_W-1:0] sub;
    logic [7:0]       tmr;
  } ccp_tb_type;

  ccp_tb_type s_reg, s_next;
  logic       step;

  if (DIV_W != DC_W) begin : g_chk
    $error("timebase fraction must match the duty low bits");
  end

  assign step   = run && (s_reg.sub == '1);
  assign reload = step && (s_reg.tmr == period);
  assign pos    = {s_reg.tmr, s_reg.sub};

  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next = '0;
    end else begin
      s_next.sub = s_reg.sub + 1'b1;
      // RL16 period of limit plus one
      if (step) begin
        s_next.tmr = reload ? 8'h00 : s_reg.tmr + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : ccp_timebase

// ===== core/ccp_unit.sv
// two-channel capture/compare/PWM unit with register port and interrupt
//
// What this block does
// RL1 - each of two channels holds one 16-bit capture/compare/duty register
// RL2 - mode 0000 disables the channel and returns its state to reset
// RL3 - mode 0010 toggles the pin on each compare match and sets the flag
// RL4 - mode 0100 captures on falling edges, 0101 on rising edges
// RL5 - mode 0110 captures every 4th rising edge, 0111 every 16th
// RL6 - mode 1000 starts pin low, forces it high on match, sets flag
// RL7 - mode 1001 starts pin high, forces it low on match, sets flag
// RL8 - mode 1010 only sets the flag on match; pin stays with the port
// RL9 - mode 1011 emits a timer-reset and conversion trigger on match, sets flag
// RL10 - modes 11xx are PWM; control bits 5-4 are the duty low bits
// RL11 - control bits 7 and 6 always read zero
// RL12 - with direction bit 0 the channel output overrides the port latch
// RL13 - a config bit puts channel two on the default or alternate pin
// RL14 - at period end: clear timer, set pin unless duty zero, load duty
// RL15 - duty writes apply at next period end; active duty is read-only
// RL16 - PWM period is period limit plus one timer steps
// RL17 - clearing channel two control forces its output latch low
// RL18 - reserved codes 0001 and 0011 behave as disabled
// RL19 - capture and compare use the external 16-bit timer value
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ccp_unit
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // timer and triggers
  input  wire logic [15:0] timer_value,
  output logic             special_event,
  output logic             irq,
  // pins: 0 first channel, 1 second default, 2 second alternate
  input  wire logic [2:0]  pin_in,
  input  wire logic [2:0]  port_latch,
  output logic [2:0]       pin_out,
  output logic [2:0]       pin_oe
);
  // ---------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------
  ccp_state_type s_reg, s_next;
  ccp_bus_type   bus;
  logic [1:0]    cap;
  logic [1:0]    cap_src;
  logic          pwm_run;
  logic          reload;
  logic [9:0]    pos;
  logic [1:0]    drv;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // RL13 second channel pin choice
  assign cap_src[0] = pin_in[0];
  assign cap_src[1] = s_reg.cfg[CFG_PINSEL] ? pin_in[1] : pin_in[2];

  assign pwm_run = (ccp_class(s_reg.ctrl[0][3:0]) == CCP_PWM)
                   || (ccp_class(s_reg.ctrl[1][3:0]) == CCP_PWM);

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_edge
    ccp_edge u_edge (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  (cap_src[g]),
      .mode    (s_reg.ctrl[g][3:0]),
      .cap     (cap[g])
    );
  end

  ccp_timebase #(
    .DIV_W (DC_W)
  ) u_timebase (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (pwm_run),
    .period  (s_reg.period),
    .reload  (reload),
    .pos     (pos)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0]    ev;
    logic [1:0]    clr;
    ccp_class_type cls;
    logic [3:0]    m;
    logic          hit;
    logic          wc;
    logic          wd;
    logic [9:0]    duty;
    logic          sel;
    ev           = 2'b00;
    clr          = 2'b00;
    cls          = CCP_OFF;
    m            = MODE_OFF;
    hit          = 1'b0;
    wc           = 1'b0;
    wd           = 1'b0;
    duty         = 10'h000;
    sel          = 1'b0;
    drv          = 2'b00;
    s_next       = s_reg;
    s_next.special = 1'b0;
    s_next.rdata   = 16'h0000;

    for (int i = 0; i < 2; i++) begin
      m    = s_reg.ctrl[i][3:0];
      cls  = ccp_class(m);
      // RL19 compare against external timer
      hit  = (timer_value == s_reg.ccpr[i]);
      wc   = bus.wr && (bus.addr == ((i == 0) ? OFF_CTRL0 : OFF_CTRL1));
      wd   = bus.wr && (bus.addr == ((i == 0) ? OFF_CCPR0 : OFF_CCPR1));
      duty = {s_reg.ccpr[i][7:0], s_reg.ctrl[i][DC_LSB +: DC_W]};
      drv[i] = ccp_drives(m);
      s_next.mprev[i] = hit && (cls == CCP_CMP);

      // RL1 one 16-bit register per channel
      // RL15 high byte read-only in PWM
      if (wd) begin
        if (cls == CCP_PWM) begin
          s_next.ccpr[i][7:0] = bus.wdata[7:0];
        end else begin
          s_next.ccpr[i] = bus.wdata;
        end
      end

      case (cls)
        // RL2 disabled channel back to reset
        // RL18 reserved codes land here
        CCP_OFF: begin
          s_next.latch[i]  = 1'b0;
          s_next.act_lo[i] = 2'b00;
          s_next.mprev[i]  = 1'b0;
        end
        // RL4 edge capture
        // RL5 prescaled capture strobe
        CCP_CAP: begin
          if (cap[i]) begin
            s_next.ccpr[i] = timer_value;
            ev[i]          = 1'b1;
          end
        end
        // only the first cycle of a match acts, so a held timer fires once
        CCP_CMP: begin
          if (hit && !s_reg.mprev[i]) begin
            ev[i] = 1'b1;
            case (m)
              // RL3 toggle on match
              MODE_TOGGLE: s_next.latch[i] = ~s_reg.latch[i];
              // RL6 force high on match
              MODE_SET_HI: s_next.latch[i] = 1'b1;
              // RL7 force low on match
              MODE_SET_LO: s_next.latch[i] = 1'b0;
              // RL9 special event trigger
              MODE_SPECIAL: s_next.special = 1'b1;
              // RL8 flag only
              default: s_next.latch[i] = s_reg.latch[i];
            endcase
          end
        end
        // RL10 ten-bit duty from byte and low bits
        CCP_PWM: begin
          // RL14 period end reload
          if (reload) begin
            s_next.latch[i]         = (duty != 10'h000);
            s_next.ccpr[i][15:8]    = s_reg.ccpr[i][7:0];
            s_next.act_lo[i]        = s_reg.ctrl[i][DC_LSB +: DC_W];
          // clear one step early: the registered pin is then high for exactly duty clocks
          end else if (pos + 10'h001 == {s_reg.ccpr[i][15:8], s_reg.act_lo[i]}) begin
            s_next.latch[i] = 1'b0;
          end
        end
        default: s_next.latch[i] = 1'b0;
      endcase

      // control write last, so entering mode 1000 or 1001 sets the pin level
      if (wc) begin
        s_next.ctrl[i] = bus.wdata[CTRL_W-1:0];
        if (bus.wdata[3:0] != m) begin
          // RL6 enter low
          if (bus.wdata[3:0] == MODE_SET_HI) begin
            s_next.latch[i] = 1'b0;
          end
          // RL7 enter high
          if (bus.wdata[3:0] == MODE_SET_LO) begin
            s_next.latch[i] = 1'b1;
          end
        end
        // RL17 cleared control drops latch
        if (bus.wdata[3:0] == MODE_OFF) begin
          s_next.latch[i] = 1'b0;
        end
      end
    end

    // -------------------------------------------------------------
    // shared registers and interrupt
    // -------------------------------------------------------------
    if (bus.wr && bus.addr == OFF_PERIOD) begin
      s_next.period = bus.wdata[7:0];
    end
    if (bus.wr && bus.addr == OFF_MASK) begin
      s_next.mask = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == OFF_CONFIG) begin
      s_next.cfg = bus.wdata[3:0];
    end
    if (bus.wr && bus.addr == OFF_STATUS) begin
      clr = bus.wdata[1:0];
    end
    // a new event outranks a clear in the same cycle
    s_next.status = (s_reg.status & ~clr) | ev;

    // -------------------------------------------------------------
    // pins
    // -------------------------------------------------------------
    // RL12 channel output over port latch
    s_next.pout[0] = drv[0] ? s_next.latch[0] : port_latch[0];
    s_next.poe     = ~s_next.cfg[CFG_DIR_LSB +: 3];
    sel            = s_next.cfg[CFG_PINSEL];
    // RL13 default or alternate pin
    s_next.pout[1] = (sel && drv[1]) ? s_next.latch[1] : port_latch[1];
    s_next.pout[2] = (!sel && drv[1]) ? s_next.latch[1] : port_latch[2];

    // -------------------------------------------------------------
    // read data, one cycle after the strobe
    // -------------------------------------------------------------
    if (bus.rd) begin
      case (bus.addr)
        // RL11 upper control bits zero
        OFF_CTRL0:  s_next.rdata = {10'h000, s_reg.ctrl[0]};
        OFF_CTRL1:  s_next.rdata = {10'h000, s_reg.ctrl[1]};
        OFF_CCPR0:  s_next.rdata = s_reg.ccpr[0];
        OFF_CCPR1:  s_next.rdata = s_reg.ccpr[1];
        OFF_PERIOD: s_next.rdata = {8'h00, s_reg.period};
        OFF_STATUS: s_next.rdata = {14'h0000, s_reg.status};
        OFF_MASK:   s_next.rdata = {14'h0000, s_reg.mask};
        OFF_CONFIG: s_next.rdata = {12'h000, s_reg.cfg};
        default:    s_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.ctrl   <= {CTRL_RST, CTRL_RST};
      s_reg.ccpr   <= {CCPR_RST, CCPR_RST};
      s_reg.period <= PERIOD_RST;
      s_reg.cfg    <= CFG_RST;
      s_reg.poe    <= 3'b000;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata     = s_reg.rdata;
  assign special_event = s_reg.special;
  assign pin_out       = s_reg.pout;
  assign pin_oe        = s_reg.poe;
  assign irq           = |(s_reg.status & s_reg.mask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_ctrl_hi_zero;
    bus.rd && bus.addr == OFF_CTRL1 |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == $past(s_reg.ctrl[1]);
  endproperty
  a_ctrl_hi_zero: assert property (p_ctrl_hi_zero) // RL11
    else $error("control read shows wrong bits");

  property p_off_latch;
    ccp_class(s_reg.ctrl[1][3:0]) == CCP_OFF && !bus.wr |=> !s_reg.latch[1];
  endproperty
  a_off_latch: assert property (p_off_latch) // RL17
    else $error("disabled channel latch not low");

  property p_capture;
    ccp_class(s_reg.ctrl[0][3:0]) == CCP_CAP && cap[0] && !bus.wr
      |=> s_reg.ccpr[0] == $past(timer_value) && s_reg.status[0];
  endproperty
  a_capture: assert property (p_capture) // RL4
    else $error("capture value or flag missing");

  property p_toggle;
    s_reg.ctrl[0][3:0] == MODE_TOGGLE && timer_value == s_reg.ccpr[0] && !s_reg.mprev[0] && !bus.wr
      |=> s_reg.latch[0] != $past(s_reg.latch[0]) && s_reg.status[0];
  endproperty
  a_toggle: assert property (p_toggle) // RL3
    else $error("toggle compare did not act");

  property p_special;
    special_event |-> $past(s_reg.ctrl[0][3:0] == MODE_SPECIAL || s_reg.ctrl[1][3:0] == MODE_SPECIAL)
      ##1 !special_event;
  endproperty
  a_special: assert property (p_special) // RL9
    else $error("special event without its mode or too long");

  property p_reload;
    reload && s_reg.ctrl[0][3:0] == 4'hC && s_reg.ccpr[0][7:0] != 8'h00 && !bus.wr
      |=> s_reg.latch[0] && s_reg.ccpr[0][15:8] == $past(s_reg.ccpr[0][7:0]);
  endproperty
  a_reload: assert property (p_reload) // RL14
    else $error("period end did not set pin or load duty");

  property p_readonly;
    ccp_class(s_reg.ctrl[0][3:0]) == CCP_PWM && !reload |=> $stable(s_reg.ccpr[0][15:8]);
  endproperty
  a_readonly: assert property (p_readonly) // RL15
    else $error("active duty changed outside period end");

  property p_drive;
    drv[0] && !s_reg.cfg[CFG_DIR_LSB] && !bus.wr |=> pin_oe[0] && pin_out[0] == s_reg.latch[0];
  endproperty
  a_drive: assert property (p_drive) // RL12
    else $error("channel did not drive its pin");

  property p_set_wins;
    bus.wr && bus.addr == OFF_STATUS && bus.wdata[0] && s_reg.ctrl[0][3:0] == MODE_CAP_RISE && cap[0]
      |=> s_reg.status[0];
  endproperty
  a_set_wins: assert property (p_set_wins) // RL4
    else $error("event lost against clear");

  c_capture: cover property (cap[0] && ccp_class(s_reg.ctrl[0][3:0]) == CCP_CAP);
  c_pwm_reload: cover property (reload && pwm_run ##[1:40] !s_reg.latch[0]);
  c_special: cover property (special_event);
  c_irq: cover property (irq);
endmodule : ccp_unit

// ===== inc/ccp_pkg.sv
// shared constants and types of the capture/compare/PWM unit
package ccp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          CCP_AW      = 4;
  localparam int          CCP_DW      = 16;
  localparam logic [3:0]  OFF_CTRL0   = 4'h0;
  localparam logic [3:0]  OFF_CTRL1   = 4'h1;
  localparam logic [3:0]  OFF_CCPR0   = 4'h2;
  localparam logic [3:0]  OFF_CCPR1   = 4'h3;
  localparam logic [3:0]  OFF_PERIOD  = 4'h4;
  localparam logic [3:0]  OFF_STATUS  = 4'h5;
  localparam logic [3:0]  OFF_MASK    = 4'h6;
  localparam logic [3:0]  OFF_CONFIG  = 4'h7;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_W      = 6;
  localparam int          MODE_LSB    = 0;
  localparam int          DC_LSB      = 4;
  localparam int          DC_W        = 2;
  localparam int          CFG_PINSEL  = 0;
  localparam int          CFG_DIR_LSB = 1;
  localparam logic [5:0]  CTRL_RST    = 6'h00;
  localparam logic [15:0] CCPR_RST    = 16'h0000;
  localparam logic [7:0]  PERIOD_RST  = 8'hFF;
  localparam logic [3:0]  CFG_RST     = 4'hF;
  localparam logic [3:0]  PRESC_4     = 4'h3;
  localparam logic [3:0]  PRESC_16    = 4'hF;
  // ---------------------------------------------------------------
  // mode select codes
  // ---------------------------------------------------------------
  localparam logic [3:0]  MODE_OFF      = 4'h0;
  localparam logic [3:0]  MODE_TOGGLE   = 4'h2;
  localparam logic [3:0]  MODE_CAP_FALL = 4'h4;
  localparam logic [3:0]  MODE_CAP_RISE = 4'h5;
  localparam logic [3:0]  MODE_CAP_4    = 4'h6;
  localparam logic [3:0]  MODE_CAP_16   = 4'h7;
  localparam logic [3:0]  MODE_SET_HI   = 4'h8;
  localparam logic [3:0]  MODE_SET_LO   = 4'h9;
  localparam logic [3:0]  MODE_SWINT    = 4'hA;
  localparam logic [3:0]  MODE_SPECIAL  = 4'hB;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CCP_OFF = 4'b0001,
    CCP_CAP = 4'b0010,
    CCP_CMP = 4'b0100,
    CCP_PWM = 4'b1000
  } ccp_class_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ccp_bus_type;

  typedef struct packed {
    logic       prev;
    logic [3:0] cnt;
  } ccp_edge_type;

  typedef struct packed {
    logic [1:0][5:0]  ctrl;
    logic [1:0][15:0] ccpr;
    logic [1:0][1:0]  act_lo;
    logic [1:0]       latch;
    logic [1:0]       mprev;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic [3:0]       cfg;
    logic [7:0]       period;
    logic [15:0]      rdata;
    logic             special;
    logic [2:0]       pout;
    logic [2:0]       poe;
  } ccp_state_type;

  function automatic ccp_class_type ccp_class(input logic [3:0] m);
    case (m)
      MODE_TOGGLE, MODE_SET_HI, MODE_SET_LO, MODE_SWINT, MODE_SPECIAL: ccp_class = CCP_CMP;
      MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16: ccp_class = CCP_CAP;
      default: ccp_class = (m[3:2] == 2'b11) ? CCP_PWM : CCP_OFF;
    endcase
  endfunction : ccp_class

  // compare modes that own the pin, and every PWM mode
  function automatic logic ccp_drives(input logic [3:0] m);
    ccp_drives = (m == MODE_TOGGLE) || (m == MODE_SET_HI) || (m == MODE_SET_LO)
                 || (ccp_class(m) == CCP_PWM);
  endfunction : ccp_drives
endpackage : ccp_pkg

// ===== tb/ccp_pin_model.sv
// outside signal source on the three capture/compare pins
`timescale 1ns/1ps
module ccp_pin_model (
  // unit side
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  // stimulus side
  input  wire logic [2:0] ext_level,
  // resolved pin level
  output logic [2:0]      pin_in
);
  // a driven pin shows the unit's level, so the outside source never fights it
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : ccp_pin_model

// ===== tb/ccp_unit_tb_top.sv
// self-checking bench of the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_unit_tb_top
  import ccp_pkg::*;
;
  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] timer_value;
  logic [15:0] rd_val;
  logic [15:0] v;
  logic        reg_wr;
  logic        reg_rd;
  logic        special_event;
  logic        irq;
  logic [2:0]  pin_in;
  logic [2:0]  port_latch;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  logic [2:0]  ext_level;
  logic [3:0]  m;
  logic        pre;
  logic        post;
  int          errors;
  int          num_checks;
  int          seed;
  int          cnt_p;
  int          cnt_s;
  int          exp_cap;
  int          nrise;
  logic [3:0]  cmp_modes [8] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'h0, 4'h1, 4'h3};
  logic [15:0] rst_vals [8]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h000F};

  ccp_unit i_ccp_unit (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_value(timer_value),
    .special_event(special_event), .irq(irq), .pin_in(pin_in), .port_latch(port_latch),
    .pin_out(pin_out), .pin_oe(pin_oe));
  ccp_pin_model i_ccp_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  // timer and pin move together so the captured value is unambiguous
  task edge_to(input logic lvl, input logic [15:0] t);
    @(posedge clk_sys);
    timer_value  <= t;
    ext_level[0] <= lvl;
    tick(4);
  endtask : edge_to

  // pin high time and trigger pulses over n cycles
  task count(input int n);
    cnt_p = 0;
    cnt_s = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      cnt_p += pin_out[0];
      cnt_s += special_event;
    end
  endtask : count

  initial begin
    seed        = 32'h708D2998;
    errors      = 0;
    num_checks  = 0;
    rst_n       = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    timer_value = 16'h0000;
    port_latch  = 3'h0;
    ext_level   = 3'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // -------------------------------------------------------------
    // reset values, unimplemented bits, unmapped index
    // -------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      rd(4'(i));
      chk(rd_val, rst_vals[i]);
    end
    wr(OFF_CTRL0, 16'hFFFF);
    rd(OFF_CTRL0);
    chk(rd_val, 16'h003F);
    wr(4'h9, 16'hFFFF);
    rd(4'h9);
    chk(rd_val, 16'h0000);
    // -------------------------------------------------------------
    // capture modes, edge kind and prescale
    // -------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      m = MODE_CAP_FALL + 4'(i);
      wr(OFF_CTRL0, 16'h0000);
      wr(OFF_CCPR0, 16'h0000);
      wr(OFF_STATUS, 16'h0003);
      wr(OFF_CTRL0, {12'h000, m});
      exp_cap = 0;
      nrise = 0;
      for (int k = 0; k < ((i == 3) ? 17 : 6); k++) begin
        v = 16'($random(seed));
        edge_to(1'b1, v);
        nrise++;
        if (i == 1 || (i == 2 && nrise % 4 == 0) || (i == 3 && nrise % 16 == 0)) exp_cap = v;
        v = 16'($random(seed));
        edge_to(1'b0, v);
        if (i == 0) exp_cap = v;
      end
      rd(OFF_CCPR0);
      chk(rd_val, exp_cap[15:0]);
      rd(OFF_STATUS);
      chk(rd_val, 16'h0001);
    end
    // capture strobe and flag clear in one cycle: the new event wins
    wr(OFF_CTRL0, {12'h000, MODE_CAP_RISE});
    @(posedge clk_sys);
    ext_level[0] <= 1'b1;
    timer_value  <= 16'h5A5A;
    reg_wr       <= 1'b1;
    reg_addr     <= OFF_STATUS;
    reg_wdata    <= 16'h0001;
    @(posedge clk_sys);
    reg_wr       <= 1'b0;
    rd(OFF_STATUS);
    chk(rd_val, 16'h0001);
    rd(OFF_CCPR0);
    chk(rd_val, 16'h5A5A);
    // -------------------------------------------------------------
    // interrupt: masked, unmasked, cleared
    // -------------------------------------------------------------
    chk({15'h0000, irq}, 16'h0000);
    wr(OFF_MASK, 16'h0001);
    tick(1);
    chk({15'h0000, irq}, 16'h0001);
    wr(OFF_STATUS, 16'h0001);
    tick(1);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFF_MASK, 16'h0000);
    // -------------------------------------------------------------
    // compare modes and reserved codes on the first channel pin
    // -------------------------------------------------------------
    wr(OFF_CONFIG, 16'h000D);
    for (int i = 0; i < 8; i++) begin
      m = cmp_modes[i];
      v = 16'($random(seed));
      timer_value <= ~v;
      port_latch  <= 3'($random(seed));
      wr(OFF_CTRL0, 16'h0000);
      wr(OFF_CCPR0, v);
      wr(OFF_STATUS, 16'h0003);
      wr(OFF_CTRL0, {12'h000, m});
      tick(2);
      pre  = (m == MODE_SET_LO) ? 1'b1 : (m == MODE_TOGGLE || m == MODE_SET_HI) ? 1'b0 : port_latch[0];
      post = (m == MODE_SET_LO) ? 1'b0 : (m == MODE_TOGGLE || m == MODE_SET_HI) ? 1'b1 : port_latch[0];
      chk({15'h0000, pin_out[0]}, {15'h0000, pre});
      @(posedge clk_sys);
      timer_value <= v;
      count(6);
      chk({15'h0000, pin_out[0]}, {15'h0000, post});
      chk(cnt_s[15:0], (m == MODE_SPECIAL) ? 16'h0001 : 16'h0000);
      rd(OFF_STATUS);
      chk(rd_val, (m[3] || m == MODE_TOGGLE) ? 16'h0001 : 16'h0000);
      timer_value <= ~v;
    end
    // -------------------------------------------------------------
    // second channel on default and alternate pin
    // -------------------------------------------------------------
    timer_value <= 16'h1234;
    wr(OFF_CONFIG, 16'h0001);
    wr(OFF_CTRL1, {12'h000, MODE_SET_LO});
    tick(2);
    chk({13'h0000, pin_out}, {13'h0000, port_latch[2], 1'b1, port_latch[0]});
    chk({13'h0000, pin_oe}, 16'h0007);
    wr(OFF_CONFIG, 16'h0000);
    tick(2);
    chk({13'h0000, pin_out}, {13'h0000, 1'b1, port_latch[1], port_latch[0]});
    wr(OFF_CTRL1, 16'h0000);
    // -------------------------------------------------------------
    // PWM: period, duty, buffered duty reload
    // -------------------------------------------------------------
    wr(OFF_PERIOD, 16'h0003);
    wr(OFF_CCPR0, 16'h0002);
    wr(OFF_CTRL0, 16'h001C);
    tick(48);
    rd(OFF_CCPR0);
    chk(rd_val, 16'h0202);
    count(32);
    chk(cnt_p[15:0], 16'd18);
    wr(OFF_CCPR0, 16'hAA03);
    tick(48);
    rd(OFF_CCPR0);
    chk(rd_val, 16'h0303);
    count(32);
    chk(cnt_p[15:0], 16'd26);
    rd(OFF_CTRL0);
    chk(rd_val, 16'h001C);
    conclude();
  end
endmodule : ccp_unit_tb_top
